// >>> atc_isa_peer.sv
`timescale 1ns/1ns
// ------------------------------------------------------------
// isa peripheral on one dma channel, slow ready
// ------------------------------------------------------------
module atc_isa_peer #(
  parameter int CH = 1
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_en,
  input wire logic [7:0] i_dack,
  output logic [7:0] o_drq,
  output logic o_chrdy,
  output logic [15:0] o_data,
  output logic [7:0] o_beats
);
  logic [1:0] wait_reg;
  logic ack_reg;
  logic ack;
  assign ack = i_dack[CH];
  assign o_drq = i_en ? (8'h01 << CH) : 8'h00;
  assign o_chrdy = !ack || (wait_reg == 2'h3);
  // data stands only while ready; otherwise the inverse shows
  assign o_data = (ack && o_chrdy) ? 16'h5A00 + o_beats
                                   : ~(16'h5A00 + o_beats);
  // wait count per grant, beat count per grant end
  always_ff @(posedge i_clk)
  begin
    ack_reg <= ack;
    if (i_rst || !ack)
      wait_reg <= 2'h0;
    else if (wait_reg != 2'h3)
      wait_reg <= wait_reg + 2'h1;
    if (i_rst)
      o_beats <= 8'h00;
    else if (ack_reg && !ack)
      o_beats <= o_beats + 8'h01;
  end
endmodule

// >>> atc_pkg.sv
package atc_pkg;

  // ------------------------------------------------------------
  // sizes and fixed positions
  // ------------------------------------------------------------
  localparam int ATC_NUM_IRQ = 16;
  localparam int ATC_NUM_DMA = 8;
  localparam int ATC_NUM_TMR = 3;
  localparam int ATC_FIFO_DEPTH = 16;
  localparam int ATC_FIFO_WIDTH = 48;
  // primary line fed by the secondary controller
  localparam int ATC_CASC_IRQ = 2;
  // primary dma channel carrying the secondary controller
  localparam int ATC_CASC_CH = 4;
  // timer counters and their jobs
  localparam int ATC_TMR_TICK = 0;
  localparam int ATC_TMR_REFRESH = 1;
  localparam int ATC_TMR_SPEAKER = 2;
  // lines reachable from pins: all but 0, 2 and 13
  localparam logic [15:0] ATC_EXT_IRQ_MASK = 16'hDFFA;
  // dma request lines that may be serviced: all but the cascade
  localparam logic [7:0] ATC_DMA_USABLE = 8'hEF;
  // legacy at i/o space is claimed below this address
  localparam logic [15:0] ATC_AT_IO_LIMIT = 16'h0100;
  // timer counting input in khz, and the core clock in mhz
  localparam int ATC_TMR_IN_KHZ = 1193;
  localparam int ATC_CLK_MHZ = 100;
  // core cycles per timer input period, rounded down
  localparam int ATC_TMR_CYCLES = (ATC_CLK_MHZ * 1000) / ATC_TMR_IN_KHZ;
  // reset values
  localparam logic [15:0] ATC_TMR_RESET = 16'h0000;
  localparam logic [31:0] ATC_ADDR_RESET = 32'h0000_0000;

  // ------------------------------------------------------------
  // types
  // ------------------------------------------------------------
  // dma sequencer, gray along idle-xfer-wait
  typedef enum logic [1:0] {
    ATC_DMA_IDLE = 2'b00,
    ATC_DMA_XFER = 2'b01,
    ATC_DMA_WAIT = 2'b11,
    ATC_DMA_CASC = 2'b10
  } atc_dma_st_t;

  // one word handed to the memory side
  typedef struct packed {
    logic [31:0] addr;
    logic [15:0] data;
  } atc_mem_word_t;

  // routing of the four shared pci interrupt lines
  typedef struct packed {
    logic [3:0] en;
    logic [3:0][3:0] irq;
  } atc_pci_route_t;

  // channel programming strobe
  typedef struct packed {
    logic valid;
    logic [2:0] ch;
    logic [31:0] addr;
    logic [15:0] count;
  } atc_dma_load_t;

  // nmi enables
  typedef struct packed {
    logic disable_all;
    logic serr_en;
    logic perr_en;
  } atc_nmi_ctl_t;

endpackage

// >>> atc_props.sv
`timescale 1ns/1ns
// ------------------------------------------------------------
// port checker
// ------------------------------------------------------------
module atc_props (
  input wire logic I_MCLK,
  input wire logic I_RST,
  input wire logic [15:0] I_IRQ,
  input wire logic [15:0] I_IRQ_LEVEL,
  input wire logic [15:0] I_IRQ_MASK,
  input wire logic O_INTR,
  input wire logic I_SPK_GATE,
  input wire logic O_SPEAKER,
  input wire logic [7:0] I_CH_CASCADE,
  input wire logic I_CHRDY,
  input wire logic [7:0] O_DACK,
  input wire logic [31:0] O_DMA_ADDR,
  input wire logic O_MASTER_GRANT,
  input wire logic I_MST_CYC,
  input wire logic I_MST_MEM,
  input wire logic O_PCI_FWD,
  input wire logic O_ISA_LOCAL,
  input wire logic I_SERR_N,
  input wire atc_pkg::atc_nmi_ctl_t I_NMI_CTL,
  input wire logic I_NMI_CLEAR,
  input wire logic O_NMI,
  input wire logic I_IO_VALID,
  input wire logic [15:0] I_IO_ADDR,
  input wire logic O_IO_CLAIM
);
  import atc_pkg::*;
  // one clock domain for all checks
  default clocking cb @(posedge I_MCLK);
  endclocking
  default disable iff (I_RST);
  AST_LEVEL_REQ: assert property (
    |(I_IRQ & I_IRQ_LEVEL & ~I_IRQ_MASK & ATC_EXT_IRQ_MASK) |=> O_INTR)
    else $error("level request not signalled");
  AST_SPK_GATE: assert property (!I_SPK_GATE |=> !O_SPEAKER)
    else $error("speaker on while gated");
  AST_DACK_CH4: assert property (
    $onehot0(O_DACK) && !O_DACK[ATC_CASC_CH])
    else $error("bad dma grant");
  AST_GRANT_CASC: assert property (
    O_MASTER_GRANT |-> |(O_DACK & I_CH_CASCADE))
    else $error("grant without cascade channel");
  AST_CHRDY_HOLD: assert property (
    |O_DACK && !O_MASTER_GRANT && !I_CHRDY |=> $stable(O_DMA_ADDR))
    else $error("cycle not stretched");
  AST_MEM_FWD: assert property (
    O_MASTER_GRANT && I_MST_CYC && I_MST_MEM |=> O_PCI_FWD && !O_ISA_LOCAL)
    else $error("memory cycle not forwarded");
  AST_IO_LOCAL: assert property (
    O_MASTER_GRANT && I_MST_CYC && !I_MST_MEM |=> O_ISA_LOCAL && !O_PCI_FWD)
    else $error("io cycle not kept local");
  AST_NMI_SERR: assert property (
    !I_SERR_N && I_NMI_CTL.serr_en && !I_NMI_CTL.disable_all |=> O_NMI)
    else $error("nmi missing on system error");
  AST_NMI_STICKY: assert property (
    O_NMI && !I_NMI_CLEAR |=> O_NMI)
    else $error("nmi dropped without clear");
  AST_IO_CLAIM: assert property (
    O_IO_CLAIM == $past(I_IO_VALID && (I_IO_ADDR < ATC_AT_IO_LIMIT)))
    else $error("io claim wrong");
endmodule

bind atc_top atc_props u_props (.I_MCLK, .I_RST, .I_IRQ, .I_IRQ_LEVEL,
  .I_IRQ_MASK, .O_INTR, .I_SPK_GATE, .O_SPEAKER, .I_CH_CASCADE, .I_CHRDY,
  .O_DACK, .O_DMA_ADDR, .O_MASTER_GRANT, .I_MST_CYC, .I_MST_MEM,
  .O_PCI_FWD, .O_ISA_LOCAL, .I_SERR_N, .I_NMI_CTL, .I_NMI_CLEAR, .O_NMI,
  .I_IO_VALID, .I_IO_ADDR, .O_IO_CLAIM);

// >>> atc_top.sv
`timescale 1ns/1ns
// Notes on behaviour
// - two cascaded dma controllers, seven channels
// - high page supplies upper address bits
// - stretch dma cycle while channel-ready low
// - cascade channel request grants bus master
// - three counters clocked at 1.193 MHz
// - counters give refresh, tick and tone
// - two interrupt controllers, sixteen lines
// - internal cascade, thirteen external lines
// - per line edge or level sensing
// - pci interrupts routed to chosen lines
// - nmi on system or parity error
// - positive decode of legacy i/o space
// - master memory to pci, i/o stays isa

// ------------------------------------------------------------
// fifo between the dma data capture and the memory side
// ------------------------------------------------------------
module atc_fifo #(
  parameter int WIDTH = 48,
  parameter int DEPTH = 16
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_valid,
  output logic o_ready,
  input wire logic [WIDTH-1:0] i_data,
  output logic o_valid,
  input wire logic i_ready,
  output logic [WIDTH-1:0] o_data
);
  localparam int AW = $clog2(DEPTH);

  // whole fifo state
  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0] wr;
    logic [AW-1:0] rd;
    logic [AW:0] count;
    logic has_data;
    logic has_room;
  } fifo_st_t;

  fifo_st_t s_reg;
  fifo_st_t s_next;
  logic push; // word accepted
  logic pop; // word drained
  logic [AW:0] cnt_n; // count after this cycle

  // ------------------------------------------------------------
  // next state
  // ------------------------------------------------------------
  always_comb
  begin
    s_next = s_reg;
    push = i_valid && s_reg.has_room;
    pop = i_ready && s_reg.has_data;
    cnt_n = s_reg.count;
    // write side
    if (push)
    begin
      s_next.mem[s_reg.wr] = i_data;
      s_next.wr = s_reg.wr + 1'b1;
    end
    // read side
    if (pop)
    begin
      s_next.rd = s_reg.rd + 1'b1;
    end
    // occupancy
    if (push && !pop)
    begin
      cnt_n = s_reg.count + 1'b1;
    end
    else if (pop && !push)
    begin
      cnt_n = s_reg.count - 1'b1;
    end
    s_next.count = cnt_n;
    // flags held in flops so the ports come from registers
    s_next.has_data = (cnt_n != '0);
    s_next.has_room = (cnt_n != (AW + 1)'(DEPTH));
  end

  // state register
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      s_reg <= '0;
      s_reg.has_room <= 1'b1;
    end
    else
    begin
      s_reg <= s_next;
    end
  end

  assign o_ready = s_reg.has_room;
  assign o_valid = s_reg.has_data;
  assign o_data = s_reg.mem[s_reg.rd];
endmodule

// ------------------------------------------------------------
// at compatibility logic: pic pair, timer, dma pair, nmi, decode
// ------------------------------------------------------------
module atc_top (
  input wire logic I_MCLK,
  input wire logic I_RST,
  // interrupt lines and controls
  input wire logic [15:0] I_IRQ,
  input wire logic [15:0] I_IRQ_LEVEL,
  input wire logic [15:0] I_IRQ_MASK,
  input wire logic [3:0] I_PCI_INT_N,
  input wire atc_pkg::atc_pci_route_t I_PCI_ROUTE,
  input wire logic I_INTA,
  output logic O_INTR,
  output logic [3:0] O_VECTOR,
  // interval timer
  input wire logic I_TMR_CLK,
  input wire logic [2:0][15:0] I_TMR_RELOAD,
  input wire logic I_SPK_GATE,
  output logic O_REFRESH_REQ,
  output logic O_SPEAKER,
  // dma
  input wire logic [7:0] I_DRQ,
  input wire logic [7:0] I_CH_CASCADE,
  input wire atc_pkg::atc_dma_load_t I_DMA_LOAD,
  input wire logic I_CHRDY,
  input wire logic [15:0] I_ISA_DATA,
  output logic [7:0] O_DACK,
  output logic O_TC,
  output logic [31:0] O_DMA_ADDR,
  output logic O_MASTER_GRANT,
  input wire logic I_MST_CYC,
  input wire logic I_MST_MEM,
  output logic O_PCI_FWD,
  output logic O_ISA_LOCAL,
  output logic O_MEM_VALID,
  input wire logic I_MEM_READY,
  output atc_pkg::atc_mem_word_t O_MEM_WORD,
  // nmi
  input wire logic I_SERR_N,
  input wire logic I_PERR_N,
  input wire atc_pkg::atc_nmi_ctl_t I_NMI_CTL,
  input wire logic I_NMI_CLEAR,
  output logic O_NMI,
  // legacy i/o decode
  input wire logic I_IO_VALID,
  input wire logic [15:0] I_IO_ADDR,
  output logic O_IO_CLAIM
);
  import atc_pkg::*;

  // whole block state
  typedef struct packed {
    logic [15:0] irq_prev;
    logic [15:0] irq_edge;
    logic intr;
    logic [3:0] vector;
    logic tclk_prev;
    logic [2:0][15:0] tcnt;
    logic [2:0] tout;
    logic refresh;
    logic spk; // gated tone, held in a flop
    atc_dma_st_t st;
    logic [2:0] ch;
    logic [7:0][31:0] addr;
    logic [7:0][15:0] cnt;
    logic [7:0] armed;
    logic [7:0] dack;
    logic tc;
    logic [31:0] dma_addr;
    logic grant;
    logic pci_fwd;
    logic isa_local;
    logic nmi;
    logic io_claim;
  } atc_state_t;

  atc_state_t s_reg;
  atc_state_t s_next;
  logic [15:0] raw; // request levels before sensing
  logic [15:0] req; // sensed and unmasked requests
  logic [7:0] prim; // primary controller inputs
  logic tick; // one timer input edge
  logic [7:0] elig; // dma requests that may be served
  logic push_valid; // data word ready for the fifo
  logic push_ready; // fifo has room
  logic nmi_set; // error seen this cycle

  // lowest set bit of eight, fixed priority
  function automatic logic [2:0] first_set8(input logic [7:0] v);
    logic [2:0] r;
    r = 3'h0;
    for (int k = 7; k >= 0; k--)
    begin
      if (v[k])
      begin
        r = 3'(k);
      end
    end
    return r;
  endfunction

  // timer counter step: count down, reload after one
  function automatic logic [15:0] tmr_step(input logic [15:0] c,
                                           input logic [15:0] ld);
    logic [15:0] r;
    r = c - 16'h0001;
    if (c <= 16'h0001)
    begin
      r = ld;
    end
    return r;
  endfunction

  // ------------------------------------------------------------
  // next state
  // ------------------------------------------------------------
  always_comb
  begin
    s_next = s_reg;
    s_next.tc = 1'b0;
    s_next.pci_fwd = 1'b0;
    s_next.isa_local = 1'b0;
    s_next.refresh = 1'b0;

    tick = I_TMR_CLK && !s_reg.tclk_prev;
    s_next.tclk_prev = I_TMR_CLK;
    // three counters, each reload toggles its output
    for (int t = 0; t < ATC_NUM_TMR; t++)
    begin
      if (tick)
      begin
        s_next.tcnt[t] = tmr_step(s_reg.tcnt[t], I_TMR_RELOAD[t]);
        if (s_reg.tcnt[t] <= 16'h0001)
        begin
          s_next.tout[t] = !s_reg.tout[t];
          // refresh request is a pulse per period
          if (t == ATC_TMR_REFRESH)
          begin
            s_next.refresh = 1'b1;
          end
        end
      end
    end

    // speaker gate applied before the flop so the pin is registered
    s_next.spk = s_next.tout[ATC_TMR_SPEAKER] && I_SPK_GATE;

    // thirteen pin lines, timer tick on line 0
    raw = I_IRQ & ATC_EXT_IRQ_MASK;
    raw[ATC_TMR_TICK] = s_reg.tout[ATC_TMR_TICK];
    // shared pci lines onto chosen inputs
    for (int p = 0; p < 4; p++)
    begin
      if (I_PCI_ROUTE.en[p] && !I_PCI_INT_N[p])
      begin
        raw[I_PCI_ROUTE.irq[p]] = 1'b1;
      end
    end
    // keep the cascade input free of outside sources
    raw[ATC_CASC_IRQ] = 1'b0;
    s_next.irq_prev = raw;
    // edge latch, acknowledge clears, new edge wins
    s_next.irq_edge = s_reg.irq_edge;
    if (I_INTA)
    begin
      s_next.irq_edge[s_reg.vector] = 1'b0;
    end
    s_next.irq_edge = s_next.irq_edge | (raw & ~s_reg.irq_prev);
    // per line choice of level or latched edge
    req = ((I_IRQ_LEVEL & raw) | (~I_IRQ_LEVEL & s_reg.irq_edge))
          & ~I_IRQ_MASK;
    prim = req[7:0];
    // secondary output drives primary line 2
    prim[ATC_CASC_IRQ] = |req[15:8];
    s_next.intr = |prim;
    s_next.vector = {1'b0, first_set8(prim)};
    if (prim[first_set8(prim)] && first_set8(prim) == 3'(ATC_CASC_IRQ))
    begin
      s_next.vector = {1'b1, first_set8(req[15:8])};
    end

    // seven usable channels over two controllers
    // channel 4 only carries the secondary
    elig = I_DRQ & (s_reg.armed | I_CH_CASCADE) & ATC_DMA_USABLE;
    push_valid = 1'b0;
    case (s_reg.st)
      ATC_DMA_IDLE:
      begin
        // pick the highest priority request
        if (|elig)
        begin
          s_next.ch = first_set8(elig);
          s_next.dack[first_set8(elig)] = 1'b1;
          if (I_CH_CASCADE[first_set8(elig)])
          begin
            // cascade request hands the bus over
            s_next.grant = 1'b1;
            s_next.st = ATC_DMA_CASC;
          end
          else
          begin
            // full 32-bit address incl high page
            s_next.dma_addr = s_reg.addr[first_set8(elig)];
            s_next.st = ATC_DMA_XFER;
          end
        end
      end
      ATC_DMA_XFER:
      begin
        // address phase, then data phase
        s_next.st = ATC_DMA_WAIT;
      end
      ATC_DMA_WAIT:
      begin
        // hold the cycle while channel-ready is low
        push_valid = I_CHRDY;
        if (I_CHRDY && push_ready)
        begin
          s_next.addr[s_reg.ch] = s_reg.addr[s_reg.ch] + 32'h0000_0001;
          s_next.cnt[s_reg.ch] = s_reg.cnt[s_reg.ch] - 16'h0001;
          s_next.dack = '0;
          s_next.st = ATC_DMA_IDLE;
          // terminal count ends the channel's block
          if (s_reg.cnt[s_reg.ch] == 16'h0000)
          begin
            s_next.tc = 1'b1;
            s_next.armed[s_reg.ch] = 1'b0;
          end
        end
      end
      ATC_DMA_CASC:
      begin
        // master memory goes to pci, i/o stays on isa
        if (I_MST_CYC)
        begin
          s_next.pci_fwd = I_MST_MEM;
          s_next.isa_local = !I_MST_MEM;
        end
        // master drops its request to give the bus back
        if (!I_DRQ[s_reg.ch])
        begin
          s_next.grant = 1'b0;
          s_next.dack = '0;
          s_next.st = ATC_DMA_IDLE;
        end
      end
      default:
      begin
        s_next.st = ATC_DMA_IDLE;
        s_next.dack = '0;
        s_next.grant = 1'b0;
      end
    endcase
    // programming a channel arms it; arming wins over completion
    if (I_DMA_LOAD.valid)
    begin
      s_next.addr[I_DMA_LOAD.ch] = I_DMA_LOAD.addr;
      s_next.cnt[I_DMA_LOAD.ch] = I_DMA_LOAD.count;
      s_next.armed[I_DMA_LOAD.ch] = 1'b1;
    end

    // sticky nmi, a new error wins over the clear
    nmi_set = !I_NMI_CTL.disable_all &&
              ((I_NMI_CTL.serr_en && !I_SERR_N) ||
               (I_NMI_CTL.perr_en && !I_PERR_N));
    s_next.nmi = (s_reg.nmi && !I_NMI_CLEAR) || nmi_set;

    // claim legacy at i/o space outright
    s_next.io_claim = I_IO_VALID && (I_IO_ADDR < ATC_AT_IO_LIMIT);
  end

  // state register
  always_ff @(posedge I_MCLK)
  begin
    if (I_RST)
    begin
      s_reg <= '0;
    end
    else
    begin
      s_reg <= s_next;
    end
  end

  // ------------------------------------------------------------
  // data buffer toward memory
  // ------------------------------------------------------------
  atc_fifo #(
    .WIDTH(ATC_FIFO_WIDTH),
    .DEPTH(ATC_FIFO_DEPTH)
  ) u_fifo (
    .i_clk(I_MCLK),
    .i_rst(I_RST),
    .i_valid(push_valid),
    .o_ready(push_ready),
    .i_data({s_reg.dma_addr, I_ISA_DATA}),
    .o_valid(O_MEM_VALID),
    .i_ready(I_MEM_READY),
    .o_data(O_MEM_WORD)
  );

  // outputs straight from state
  assign O_INTR = s_reg.intr;
  assign O_VECTOR = s_reg.vector;
  assign O_REFRESH_REQ = s_reg.refresh;
  assign O_SPEAKER = s_reg.spk;
  assign O_DACK = s_reg.dack;
  assign O_TC = s_reg.tc;
  assign O_DMA_ADDR = s_reg.dma_addr;
  assign O_MASTER_GRANT = s_reg.grant;
  assign O_PCI_FWD = s_reg.pci_fwd;
  assign O_ISA_LOCAL = s_reg.isa_local;
  assign O_NMI = s_reg.nmi;
  assign O_IO_CLAIM = s_reg.io_claim;
endmodule

// >>> test_at_compat_pic_pit_dma.sv
`timescale 1ns/1ns
module test_at_compat_pic_pit_dma;
  import atc_pkg::*;
  // ------------------------------------------------------------
  // stimulus and observed signals
  // ------------------------------------------------------------
  logic I_MCLK = 0, I_RST = 1, I_INTA = 0, I_TMR_CLK = 0, I_SPK_GATE = 0;
  logic [15:0] I_IRQ = 16'h0000, I_IRQ_LEVEL = 16'h0000;
  logic [15:0] I_IRQ_MASK = 16'h0001, I_IO_ADDR = 16'h0000;
  logic [3:0] I_PCI_INT_N = 4'hF;
  atc_pci_route_t I_PCI_ROUTE = '0;
  atc_dma_load_t I_DMA_LOAD = '0;
  atc_nmi_ctl_t I_NMI_CTL = '0;
  logic [2:0][15:0] I_TMR_RELOAD = {16'h0002, 16'h0003, 16'h0004};
  logic [7:0] I_CH_CASCADE = 8'h00, tb_drq = 8'h00, peer_drq, I_DRQ, beats;
  logic I_MST_CYC = 0, I_MST_MEM = 0, I_MEM_READY = 0, I_NMI_CLEAR = 0;
  logic I_SERR_N = 1, I_PERR_N = 1, I_IO_VALID = 0, peer_en = 0, I_CHRDY;
  logic [15:0] I_ISA_DATA, spk_q = 0;
  logic O_INTR, O_REFRESH_REQ, O_SPEAKER, O_TC, O_MASTER_GRANT, O_PCI_FWD;
  logic O_ISA_LOCAL, O_MEM_VALID, O_NMI, O_IO_CLAIM;
  logic [3:0] O_VECTOR;
  logic [7:0] O_DACK;
  logic [31:0] O_DMA_ADDR;
  atc_mem_word_t O_MEM_WORD;
  int errors = 0, checks_done = 0, tc_n = 0, rf_n = 0, sp_n = 0;
  assign I_DRQ = peer_drq | tb_drq;
  atc_top uut (.I_MCLK, .I_RST, .I_IRQ, .I_IRQ_LEVEL, .I_IRQ_MASK,
    .I_PCI_INT_N, .I_PCI_ROUTE, .I_INTA, .O_INTR, .O_VECTOR, .I_TMR_CLK,
    .I_TMR_RELOAD, .I_SPK_GATE, .O_REFRESH_REQ, .O_SPEAKER, .I_DRQ,
    .I_CH_CASCADE, .I_DMA_LOAD, .I_CHRDY, .I_ISA_DATA, .O_DACK, .O_TC,
    .O_DMA_ADDR, .O_MASTER_GRANT, .I_MST_CYC, .I_MST_MEM, .O_PCI_FWD,
    .O_ISA_LOCAL, .O_MEM_VALID, .I_MEM_READY, .O_MEM_WORD, .I_SERR_N,
    .I_PERR_N, .I_NMI_CTL, .I_NMI_CLEAR, .O_NMI, .I_IO_VALID, .I_IO_ADDR,
    .O_IO_CLAIM);
  atc_isa_peer #(.CH(1)) peer (.i_clk(I_MCLK), .i_rst(I_RST),
    .i_en(peer_en), .i_dack(O_DACK), .o_drq(peer_drq), .o_chrdy(I_CHRDY),
    .o_data(I_ISA_DATA), .o_beats(beats));
  initial
  begin
    forever #5 I_MCLK = !I_MCLK;
  end
  // event counters for pulses and toggles
  always @(posedge I_MCLK)
  begin
    tc_n += (O_TC === 1'b1);
    rf_n += (O_REFRESH_REQ === 1'b1);
    sp_n += (O_SPEAKER !== spk_q[0]);
    spk_q[0] = O_SPEAKER;
  end
  // ------------------------------------------------------------
  // shared tasks
  // ------------------------------------------------------------
  task automatic tick(input int n = 1);
    repeat (n)
    begin
      @(posedge I_MCLK);
      #1;
    end
  endtask
  task automatic chk(input string nm, input logic [31:0] ex,
                     input logic [31:0] sn);
    checks_done++;
    if (sn !== ex)
    begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", nm, ex, sn);
    end
  endtask
  task automatic close_out;
    $display("checks %0d mismatches %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic tmo(input int n);
    if (n >= 400)
    begin
      errors++;
      $display("[FAIL] wait expected done seen timeout");
      close_out;
    end
  endtask
  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task automatic t_decode;
    logic [15:0] a [4];
    a = '{16'h0000, 16'h00FF, 16'h0100, 16'hFFFF};
    foreach (a[i])
    begin
      I_IO_VALID = 1;
      I_IO_ADDR = a[i];
      tick;
      I_IO_VALID = 0;
      chk("io_claim", a[i] < 16'h0100, O_IO_CLAIM);
    end
    $display("decode done");
  endtask
  task automatic t_irq;
    I_IRQ[5] = 1;
    tick(2);
    chk("vector5", 5, O_VECTOR);
    I_IRQ[5] = 0;
    tick(2);
    chk("edge_held", 1, O_INTR);
    I_INTA = 1;
    tick;
    I_INTA = 0;
    tick(2);
    chk("acked", 0, O_INTR);
    I_IRQ_LEVEL = 16'h0208;
    I_IRQ = 16'h0208;
    tick(2);
    chk("vector9", 9, O_VECTOR);
    I_IRQ_LEVEL = 16'hFFFF;
    I_IRQ = 16'h2004;
    tick(2);
    chk("internal", 0, O_INTR);
    I_IRQ = 16'h0000;
    I_PCI_ROUTE.en = 4'h2;
    I_PCI_ROUTE.irq[1] = 4'hD;
    I_PCI_INT_N = 4'hD;
    tick(2);
    chk("pci_vector", 13, O_VECTOR);
    I_PCI_INT_N = 4'hF;
    I_IRQ_MASK = 16'hFFFF;
    I_IRQ = 16'h0020;
    tick(2);
    chk("masked", 0, O_INTR);
    I_IRQ = 16'h0000;
    I_IRQ_MASK = 16'h0001;
    I_IRQ_LEVEL = 16'h0000;
    tick(2);
    $display("interrupt done");
  endtask
  task automatic t_timer;
    sp_n = 0;
    rf_n = 0;
    I_SPK_GATE = 1;
    repeat (24)
    begin
      I_TMR_CLK = !I_TMR_CLK;
      tick(42);
    end
    chk("spk_toggles", 6, sp_n);
    chk("refresh", 4, rf_n);
    I_SPK_GATE = 0;
    tick;
    // tick counter feeds line 0
    I_IRQ_MASK = 16'hFFFE;
    tick(2);
    chk("tick_vector", 0, O_VECTOR);
    I_IRQ_MASK = 16'h0001;
    $display("timer done");
  endtask
  task automatic t_dma;
    int n;
    I_DMA_LOAD = '{1'b1, 3'h1, 32'hAB00_0010, 16'h0010};
    tick;
    I_DMA_LOAD.valid = 0;
    peer_en = 1;
    for (n = 0; n < 400 && O_DACK !== 8'h02; n++)
      tick;
    tmo(n);
    chk("dma_addr", 32'hAB00_0010, O_DMA_ADDR);
    for (n = 0; n < 400 && beats !== 8'h10; n++)
      tick;
    tmo(n);
    tick(30);
    chk("full_stall", 16, beats);
    chk("no_tc", 0, tc_n);
    I_MEM_READY = 1;
    for (int k = 0; k < 17; k++)
    begin
      for (n = 0; n < 400 && O_MEM_VALID !== 1'b1; n++)
        tick;
      tmo(n);
      chk("word_addr", 32'hAB00_0010 + k, O_MEM_WORD.addr);
      chk("word_data", 16'h5A00 + k, O_MEM_WORD.data);
      tick;
    end
    tick(20);
    chk("tc_once", 1, tc_n);
    chk("drained", 0, O_MEM_VALID);
    chk("disarmed", 0, O_DACK);
    peer_en = 0;
    $display("dma done");
  endtask
  task automatic t_casc;
    int n;
    I_CH_CASCADE = 8'h30;
    tb_drq = 8'h30;
    for (n = 0; n < 400 && O_MASTER_GRANT !== 1'b1; n++)
      tick;
    tmo(n);
    chk("casc_dack", 8'h20, O_DACK);
    I_MST_CYC = 1;
    I_MST_MEM = 1;
    tick;
    chk("pci_fwd", 1, O_PCI_FWD);
    I_MST_MEM = 0;
    tick;
    chk("isa_local", 1, O_ISA_LOCAL);
    I_MST_CYC = 0;
    tb_drq = 8'h00;
    tick(3);
    chk("released", 0, O_MASTER_GRANT);
    $display("cascade done");
  endtask
  task automatic t_nmi;
    I_NMI_CTL = '{1'b0, 1'b1, 1'b0};
    I_SERR_N = 0;
    tick;
    I_SERR_N = 1;
    tick(3);
    chk("nmi_sticky", 1, O_NMI);
    I_NMI_CLEAR = 1;
    tick;
    I_NMI_CLEAR = 0;
    I_NMI_CTL = '{1'b1, 1'b0, 1'b1};
    I_PERR_N = 0;
    tick(3);
    chk("nmi_off", 0, O_NMI);
    I_NMI_CTL.disable_all = 0;
    tick(2);
    chk("nmi_perr", 1, O_NMI);
    I_NMI_CLEAR = 1;
    tick;
    I_NMI_CLEAR = 0;
    chk("nmi_set_wins", 1, O_NMI);
    I_PERR_N = 1;
    $display("nmi done");
  endtask
  // main sequence
  initial
  begin
    tick(16);
    I_RST = 0;
    tick;
    t_decode;
    t_irq;
    t_timer;
    t_dma;
    t_casc;
    t_nmi;
    close_out;
  end
endmodule
